// ---- src/tsc_defines.svh ----
// constants for the tri-speed mac client block
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
// ===================================
// clock, timing and frame sizes
`define TSC_CLK_PERIOD_NS 10
`define TSC_MDC_HALF_NS 200
`define TSC_MDC_HALF_CYC (`TSC_MDC_HALF_NS / `TSC_CLK_PERIOD_NS)
`define TSC_PREREAD_BYTES 8
`define TSC_MDIO_FRAME_BITS 7'h40
`define TSC_MDIO_ADDR_BITS 7'h2E
`define TSC_MDIO_DATA_FIRST 7'h30
// ===================================
// host register offsets
`define TSC_REG_CTRL 4'h0
`define TSC_REG_STATUS 4'h1
`define TSC_REG_MDIO_CTL 4'h2
`define TSC_REG_MDIO_DAT 4'h3
// ===================================
// fields and reset values
`define TSC_CTRL_RESET 16'h000C
`define TSC_CTRL_HALF_BIT 8
`define TSC_MDIO_WR_BIT 13
`define TSC_MDIO_FIN_BIT 14
`define TSC_MDIO_PHY_LSB 8
`define TSC_STS_TX_IDLE_BIT 0
`define TSC_STS_RX_IDLE_BIT 1
`endif

// ---- src/tsc_pkg.sv ----
// types shared by the tri-speed mac client block
package tsc_pkg;
  // transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PREREAD = 3'h1,
    TX_WAIT_AVAIL = 3'h2,
    TX_SEND = 3'h3,
    TX_IPG = 3'h4
  } tsc_tx_state_t;
endpackage

// ---- src/tsc_skid.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module tsc_skid #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [WIDTH-1:0] tail_reg;
  logic tail_vld_reg;
  logic push;
  logic pop;

  // ready only while the second slot is free
  assign in_ready_out = ~tail_vld_reg;
  assign push = in_valid_in & ~tail_vld_reg;
  assign pop = out_valid_out & out_ready_in;

  // head slot drives the output, tail slot absorbs a stall
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      out_valid_out <= 1'b0;
      tail_vld_reg <= 1'b0;
      out_data_out <= '0;
      tail_reg <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!out_valid_out) begin
            out_valid_out <= 1'b1;
            out_data_out <= in_data_in;
          end else begin
            tail_vld_reg <= 1'b1;
            tail_reg <= in_data_in;
          end
        end
        2'b01: begin
          if (tail_vld_reg) begin
            out_data_out <= tail_reg;
            tail_vld_reg <= 1'b0;
          end else begin
            out_valid_out <= 1'b0;
          end
        end
        2'b11: begin
          out_data_out <= tail_vld_reg ? tail_reg : in_data_in;
          tail_reg <= in_data_in;
        end
        default: begin
          tail_reg <= tail_reg;
        end
      endcase
    end
  end
endmodule

// ---- src/tsc_mac.sv ----
// tri-speed mac client, line, host and management logic
`timescale 1ns/1ps
`include "tsc_defines.svh"
// ===================================
module tsc_mac
  import tsc_pkg::*;
#(
  parameter int PREREAD_BYTES = `TSC_PREREAD_BYTES,
  parameter int MDC_HALF = `TSC_MDC_HALF_CYC
) (
  // clock, reset, rate enable
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // transmit fifo client side
  input wire logic [7:0] TX_FIFO_DATA_IN,
  input wire logic TX_FIFO_EMPTY_IN,
  input wire logic TX_FIFO_AVAIL_IN,
  input wire logic TX_FIFO_EOF_IN,
  output logic TX_MAC_READ_OUT,
  output logic TX_DONE_OUT,
  output logic TX_DISCARD_OUT,
  output logic TX_STAT_EN_OUT,
  output logic [15:0] TX_STAT_VEC_OUT,
  // line transmit
  output logic [7:0] TXD_OUT,
  output logic TX_EN_OUT,
  output logic TX_ER_OUT,
  // line receive
  input wire logic [7:0] RXD_IN,
  input wire logic RX_EN_IN,
  input wire logic RX_ER_IN,
  input wire logic COL_IN,
  input wire logic CRS_IN,
  // receive client side
  output logic [7:0] RX_DATA_OUT,
  output logic RX_WRITE_OUT,
  output logic RX_EOF_OUT,
  output logic RX_ERROR_OUT,
  output logic RX_FIFO_ERROR_OUT,
  input wire logic RX_FIFO_FULL_IN,
  // host register port
  input wire logic [3:0] HADDR_IN,
  input wire logic [15:0] HDATA_IN,
  input wire logic HCS_N_IN,
  input wire logic HWRITE_N_IN,
  input wire logic HREAD_N_IN,
  output logic [15:0] HDATA_OUT,
  output logic HREADY_N_OUT,
  output logic HDATAOUT_EN_N_OUT,
  // management port
  output logic MDC_OUT,
  output logic MDO_OUT,
  output logic MDIO_EN_OUT,
  input wire logic MDI_IN
);
  localparam int TOP = PREREAD_BYTES - 1;
  tsc_tx_state_t tx_state_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_next;
  logic eof_seen_reg;
  logic [7:0] ipg_cnt_reg;
  logic [7:0] line_reg [PREREAD_BYTES];
  logic [TOP:0] line_vld_reg;
  logic [TOP:0] line_eof_reg;
  logic [14:0] byte_cnt_reg;
  logic take, take_eof, tx_abort, line_shift, out_last, defer;
  logic [15:0] ctrl_reg;
  logic crs_s1_reg, crs_s2_reg, col_s1_reg, col_s2_reg;
  logic [7:0] rxd_reg, hold_reg;
  logic rx_en_reg, rx_er_reg, hold_vld_reg, rx_err_reg, ovf_reg;
  logic mid_push, end_push, buf_ready;
  logic [10:0] buf_in;
  logic [10:0] buf_out;
  logic host_busy_reg, wr_req, rd_req;
  logic [7:0] mdc_cnt_reg;
  logic mdc_tick, mdc_fall, mdc_rise;
  logic mdio_busy_reg, mdio_fin_reg, mdio_wr_reg;
  logic [4:0] mdio_phy_reg, mdio_ra_reg;
  logic [15:0] mdio_dat_reg;
  logic [63:0] mdio_sh_reg;
  logic [6:0] mdio_bit_reg;

  // ===================================
  // transmit sequencer
  // fifo shows its head word while not empty, a read pops it
  assign take = TX_MAC_READ_OUT & ~TX_FIFO_EMPTY_IN;
  assign take_eof = take & TX_FIFO_EOF_IN;
  assign pre_next = pre_cnt_reg + {3'h0, take};
  assign tx_abort = (tx_state_reg == TX_SEND) & ~eof_seen_reg &
                    TX_FIFO_EMPTY_IN;
  assign line_shift = (tx_state_reg == TX_SEND) |
                      ((tx_state_reg == TX_PREREAD) & take);
  assign out_last = (tx_state_reg == TX_SEND) & line_vld_reg[TOP] &
                    line_eof_reg[TOP];
  assign defer = ctrl_reg[`TSC_CTRL_HALF_BIT] & (crs_s2_reg | col_s2_reg);

  // state moves only on enabled cycles
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      tx_state_reg <= TX_IDLE;
      TX_MAC_READ_OUT <= 1'b0;
      pre_cnt_reg <= 4'h0;
      eof_seen_reg <= 1'b0;
      ipg_cnt_reg <= 8'h00;
    end else if (CLK_EN_IN) begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (!TX_FIFO_EMPTY_IN && !defer) begin
            tx_state_reg <= TX_PREREAD;
            TX_MAC_READ_OUT <= 1'b1;
            pre_cnt_reg <= 4'h0;
            eof_seen_reg <= 1'b0;
          end
        end
        TX_PREREAD: begin
          pre_cnt_reg <= pre_next;
          if (take_eof || pre_next == 4'(PREREAD_BYTES)) begin
            eof_seen_reg <= take_eof;
            if (TX_FIFO_AVAIL_IN) begin
              tx_state_reg <= TX_SEND;
              TX_MAC_READ_OUT <= ~take_eof;
            end else begin
              tx_state_reg <= TX_WAIT_AVAIL;
              TX_MAC_READ_OUT <= 1'b0;
            end
          end else begin
            TX_MAC_READ_OUT <= ~TX_FIFO_EMPTY_IN;
          end
        end
        TX_WAIT_AVAIL: begin
          if (TX_FIFO_AVAIL_IN) begin
            tx_state_reg <= TX_SEND;
            TX_MAC_READ_OUT <= ~eof_seen_reg;
          end
        end
        TX_SEND: begin
          if (tx_abort) begin
            tx_state_reg <= TX_IPG;
            TX_MAC_READ_OUT <= 1'b0;
            ipg_cnt_reg <= 8'h00;
          end else begin
            if (take_eof) begin
              eof_seen_reg <= 1'b1;
              TX_MAC_READ_OUT <= 1'b0;
            end
            if (out_last) begin
              tx_state_reg <= TX_IPG;
              ipg_cnt_reg <= 8'h00;
            end
          end
        end
        TX_IPG: begin
          if (ipg_cnt_reg >= ctrl_reg[7:0]) begin
            if (TX_FIFO_AVAIL_IN && !TX_FIFO_EMPTY_IN && !defer) begin
              tx_state_reg <= TX_PREREAD;
              TX_MAC_READ_OUT <= 1'b1;
              pre_cnt_reg <= 4'h0;
              eof_seen_reg <= 1'b0;
            end else begin
              tx_state_reg <= TX_IDLE;
            end
          end else begin
            ipg_cnt_reg <= ipg_cnt_reg + 8'h01;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // pre-read line: bytes enter at 0, leave at the top
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      line_vld_reg <= '0;
      line_eof_reg <= '0;
    end else if (CLK_EN_IN) begin
      if (tx_abort) begin
        line_vld_reg <= '0;
      end else if (line_shift) begin
        line_vld_reg <= {line_vld_reg[TOP-1:0], take};
        line_eof_reg <= {line_eof_reg[TOP-1:0], take_eof};
      end
    end
  end

  // line byte storage needs no reset
  always_ff @(posedge CORE_CLK_IN) begin
    if (CLK_EN_IN && line_shift) begin
      for (int i = TOP; i > 0; i--) begin
        line_reg[i] <= line_reg[i-1];
      end
      line_reg[0] <= TX_FIFO_DATA_IN;
    end
  end

  // line outputs, completion and statistics
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      TXD_OUT <= 8'h00;
      TX_EN_OUT <= 1'b0;
      TX_ER_OUT <= 1'b0;
      TX_DONE_OUT <= 1'b0;
      TX_DISCARD_OUT <= 1'b0;
      TX_STAT_EN_OUT <= 1'b0;
      TX_STAT_VEC_OUT <= 16'h0000;
      byte_cnt_reg <= 15'h0000;
    end else if (CLK_EN_IN) begin
      // idle line shows zero, never the unreset byte storage
      TXD_OUT <= (tx_state_reg == TX_SEND && line_vld_reg[TOP]) ?
                 line_reg[TOP] : 8'h00;
      TX_EN_OUT <= ((tx_state_reg == TX_SEND) & line_vld_reg[TOP]) |
                   tx_abort;
      TX_ER_OUT <= tx_abort;
      TX_DISCARD_OUT <= tx_abort;
      TX_DONE_OUT <= out_last;
      TX_STAT_EN_OUT <= out_last | tx_abort;
      if (out_last || tx_abort) begin
        TX_STAT_VEC_OUT <= {tx_abort, byte_cnt_reg + {14'h0000, out_last}};
        byte_cnt_reg <= 15'h0000;
      end else if (tx_state_reg == TX_SEND && line_vld_reg[TOP]) begin
        byte_cnt_reg <= byte_cnt_reg + 15'h0001;
      end
    end
  end

  // ===================================
  // receive path
  // carrier and collision pass a two-stage synchroniser
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      {crs_s1_reg, crs_s2_reg, col_s1_reg, col_s2_reg} <= 4'h0;
    end else begin
      crs_s1_reg <= CRS_IN;
      crs_s2_reg <= crs_s1_reg;
      col_s1_reg <= COL_IN;
      col_s2_reg <= col_s1_reg;
    end
  end

  // line sampling on the rising edge
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      rxd_reg <= 8'h00;
      rx_en_reg <= 1'b0;
      rx_er_reg <= 1'b0;
    end else begin
      rxd_reg <= RXD_IN;
      rx_en_reg <= RX_EN_IN;
      rx_er_reg <= RX_ER_IN;
    end
  end

  // one byte held back so the last byte can carry end-of-frame
  assign mid_push = rx_en_reg & hold_vld_reg & ~ovf_reg;
  assign end_push = ~rx_en_reg & hold_vld_reg;
  assign buf_in = {end_push & ovf_reg, end_push & rx_err_reg, end_push,
                   hold_reg};

  // frame accumulation, error and overflow tracking
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      hold_reg <= 8'h00;
      hold_vld_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (rx_en_reg) begin
      hold_reg <= rxd_reg;
      hold_vld_reg <= 1'b1;
      if (rx_er_reg) rx_err_reg <= 1'b1;
      if (mid_push && !buf_ready) ovf_reg <= 1'b1;
    end else if (end_push && buf_ready) begin
      hold_vld_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end
  end

  // receive words cross a two-entry buffer toward the client
  tsc_skid #(.WIDTH(11)) u_rx_buf (
    .clk_in(CORE_CLK_IN),
    .reset_in(RESET_IN),
    .in_valid_in(mid_push | end_push),
    .in_data_in(buf_in),
    .in_ready_out(buf_ready),
    .out_valid_out(RX_WRITE_OUT),
    .out_data_out(buf_out),
    .out_ready_in(~RX_FIFO_FULL_IN)
  );
  assign RX_DATA_OUT = buf_out[7:0];
  assign RX_EOF_OUT = buf_out[8];
  assign RX_ERROR_OUT = buf_out[9];
  assign RX_FIFO_ERROR_OUT = buf_out[10];

  // ===================================
  // host register port
  assign wr_req = ~HCS_N_IN & ~HWRITE_N_IN & ~host_busy_reg;
  assign rd_req = ~HCS_N_IN & ~HREAD_N_IN & ~host_busy_reg;

  // register read decode
  function automatic logic [15:0] host_read(input logic [3:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == `TSC_REG_CTRL) begin
      v = ctrl_reg;
    end else if (addr == `TSC_REG_STATUS) begin
      v[`TSC_STS_TX_IDLE_BIT] = (tx_state_reg == TX_IDLE);
      v[`TSC_STS_RX_IDLE_BIT] = ~rx_en_reg & ~hold_vld_reg;
    end else if (addr == `TSC_REG_MDIO_CTL) begin
      v = {1'b0, mdio_fin_reg, mdio_wr_reg, mdio_phy_reg, 3'h0, mdio_ra_reg};
    end else if (addr == `TSC_REG_MDIO_DAT) begin
      v = mdio_dat_reg;
    end
    return v;
  endfunction

  // one ready pulse per access, rearmed when the strobes release
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      host_busy_reg <= 1'b0;
      HREADY_N_OUT <= 1'b1;
      HDATAOUT_EN_N_OUT <= 1'b1;
      HDATA_OUT <= 16'h0000;
      ctrl_reg <= `TSC_CTRL_RESET;
    end else begin
      HREADY_N_OUT <= 1'b1;
      HDATAOUT_EN_N_OUT <= 1'b1;
      if (HCS_N_IN || (HWRITE_N_IN && HREAD_N_IN)) host_busy_reg <= 1'b0;
      if (wr_req) begin
        host_busy_reg <= 1'b1;
        HREADY_N_OUT <= 1'b0;
        if (HADDR_IN == `TSC_REG_CTRL) ctrl_reg <= HDATA_IN;
      end else if (rd_req) begin
        host_busy_reg <= 1'b1;
        HREADY_N_OUT <= 1'b0;
        HDATAOUT_EN_N_OUT <= 1'b0;
        HDATA_OUT <= host_read(HADDR_IN);
      end
    end
  end

  // ===================================
  // management serial port
  assign mdc_tick = mdc_cnt_reg == 8'(MDC_HALF - 1);
  assign mdc_fall = mdc_tick & MDC_OUT;
  assign mdc_rise = mdc_tick & ~MDC_OUT;

  // management clock divider
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      mdc_cnt_reg <= 8'h00;
      MDC_OUT <= 1'b0;
    end else if (mdc_tick) begin
      mdc_cnt_reg <= 8'h00;
      MDC_OUT <= ~MDC_OUT;
    end else begin
      mdc_cnt_reg <= mdc_cnt_reg + 8'h01;
    end
  end

  // frame shifter; writes to the port are ignored while busy
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      mdio_busy_reg <= 1'b0;
      mdio_fin_reg <= 1'b0;
      mdio_wr_reg <= 1'b0;
      mdio_phy_reg <= 5'h00;
      mdio_ra_reg <= 5'h00;
      mdio_dat_reg <= 16'h0000;
      mdio_sh_reg <= 64'h0;
      mdio_bit_reg <= 7'h00;
      MDO_OUT <= 1'b0;
      MDIO_EN_OUT <= 1'b0;
    end else if (wr_req && !mdio_busy_reg &&
                 HADDR_IN == `TSC_REG_MDIO_DAT) begin
      mdio_dat_reg <= HDATA_IN;
    end else if (wr_req && !mdio_busy_reg &&
                 HADDR_IN == `TSC_REG_MDIO_CTL) begin
      mdio_wr_reg <= HDATA_IN[`TSC_MDIO_WR_BIT];
      mdio_phy_reg <= HDATA_IN[`TSC_MDIO_PHY_LSB +: 5];
      mdio_ra_reg <= HDATA_IN[4:0];
      mdio_busy_reg <= 1'b1;
      mdio_fin_reg <= 1'b0;
      mdio_bit_reg <= 7'h00;
      mdio_sh_reg <= {32'hFFFF_FFFF, 2'h1,
                      HDATA_IN[`TSC_MDIO_WR_BIT] ? 2'h1 : 2'h2,
                      HDATA_IN[`TSC_MDIO_PHY_LSB +: 5], HDATA_IN[4:0],
                      HDATA_IN[`TSC_MDIO_WR_BIT] ? {2'h2, mdio_dat_reg}
                                                 : 18'h00000};
    end else if (mdio_busy_reg && mdc_fall) begin
      if (mdio_bit_reg == `TSC_MDIO_FRAME_BITS) begin
        mdio_busy_reg <= 1'b0;
        mdio_fin_reg <= 1'b1;
        MDIO_EN_OUT <= 1'b0;
      end else begin
        MDO_OUT <= mdio_sh_reg[63];
        mdio_sh_reg <= {mdio_sh_reg[62:0], 1'b0};
        MDIO_EN_OUT <= mdio_wr_reg |
                       (mdio_bit_reg < `TSC_MDIO_ADDR_BITS);
        mdio_bit_reg <= mdio_bit_reg + 7'h01;
      end
    end else if (mdio_busy_reg && mdc_rise && !mdio_wr_reg &&
                 mdio_bit_reg > `TSC_MDIO_DATA_FIRST) begin
      mdio_dat_reg <= {mdio_dat_reg[14:0], MDI_IN};
    end
  end

  // ===================================
  // checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_host_wr;
    wr_req;
  endsequence
  sequence s_host_ack;
    !HREADY_N_OUT ##1 HREADY_N_OUT;
  endsequence

  property p_preread_start;
    CLK_EN_IN && tx_state_reg == TX_IDLE && !TX_FIFO_EMPTY_IN && !defer
      |=> tx_state_reg == TX_PREREAD && TX_MAC_READ_OUT;
  endproperty
  a_preread_start: assert property (p_preread_start)
    else $error("pre-read did not start on fifo not empty");

  property p_preread_bound;
    pre_cnt_reg <= 4'(PREREAD_BYTES);
  endproperty
  a_preread_bound: assert property (p_preread_bound)
    else $error("pre-read took too many bytes");

  property p_wait_no_read;
    tx_state_reg == TX_WAIT_AVAIL |-> !TX_MAC_READ_OUT;
  endproperty
  a_wait_no_read: assert property (p_wait_no_read)
    else $error("read strobe high while waiting for frame");

  property p_abort;
    CLK_EN_IN && tx_abort |=> TX_DISCARD_OUT && TX_ER_OUT &&
      !TX_MAC_READ_OUT && tx_state_reg == TX_IPG;
  endproperty
  a_abort: assert property (p_abort)
    else $error("mid-frame empty not aborted");

  property p_done_stat;
    TX_DONE_OUT |-> TX_STAT_EN_OUT && !TX_DISCARD_OUT && !TX_STAT_VEC_OUT[15];
  endproperty
  a_done_stat: assert property (p_done_stat)
    else $error("completion without statistics strobe");

  property p_recheck;
    CLK_EN_IN && tx_state_reg == TX_IPG && ipg_cnt_reg >= ctrl_reg[7:0] &&
      (!TX_FIFO_AVAIL_IN || TX_FIFO_EMPTY_IN)
      |=> tx_state_reg == TX_IDLE && !TX_MAC_READ_OUT;
  endproperty
  a_recheck: assert property (p_recheck)
    else $error("next pre-read started without frame");

  property p_host_write;
    s_host_wr |=> s_host_ack and HDATAOUT_EN_N_OUT;
  endproperty
  a_host_write: assert property (p_host_write)
    else $error("host write not acknowledged");

  property p_host_read;
    rd_req && !wr_req |=> !HREADY_N_OUT && !HDATAOUT_EN_N_OUT;
  endproperty
  a_host_read: assert property (p_host_read)
    else $error("host read ready and enable not together");

  property p_mdio_release;
    mdio_busy_reg && !mdio_wr_reg &&
      mdio_bit_reg > `TSC_MDIO_ADDR_BITS |-> !MDIO_EN_OUT;
  endproperty
  a_mdio_release: assert property (p_mdio_release)
    else $error("management enable held in read data phase");

  property p_ovf_stop;
    ovf_reg && rx_en_reg |-> !(mid_push || end_push);
  endproperty
  a_ovf_stop: assert property (p_ovf_stop)
    else $error("write continued after overflow");
endmodule

// ---- tb/tsc_client_model.sv ----
// behavioural client transmit fifo, show-ahead, facing the mac
`timescale 1ns/1ps
module tsc_client_model (
  // clock and rate enable
  input wire logic clk_in,
  input wire logic en_in,
  // mac read strobe
  input wire logic read_in,
  // fifo head word
  output logic [7:0] data_out = 8'hFF,
  output logic empty_out = 1'b1,
  output logic eof_out = 1'b0
);
  logic [8:0] fifo_q[$];
  logic [7:0] last_q = 8'h00;
  // queue one byte with its end-of-frame mark
  task automatic push(input logic [7:0] b, input logic e);
    fifo_q.push_back({e, b});
  endtask
  // pop on an enabled read, show the new head just after the edge
  always @(posedge clk_in) begin
    if (en_in && read_in && !empty_out) begin
      last_q = fifo_q[0][7:0];
      void'(fifo_q.pop_front());
    end
    #1;
    empty_out = fifo_q.size() == 0;
    data_out = empty_out ? ~last_q : fifo_q[0][7:0]; // stale data inverted
    eof_out = !empty_out && fifo_q[0][8];
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the tri-speed mac client block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, cen = 1, avail = 0, full = 0, tx_chk = 1;
  logic crs = 1, mdc, mdo, men, mdi = 1, rx_chk = 1;
  logic [63:0] mcap = '0;
  logic [15:0] phy_dat = 16'h9D26;
  logic [8:0] exp_rxd[$];
  logic rx_en = 0, rx_er = 0, hcs_n = 1, hwr_n = 1, hrd_n = 1;
  logic [7:0] rxd = 8'h00, fdata, txd, rxo;
  logic [3:0] haddr = 4'h0;
  logic [15:0] hdata = 16'h0000, hdo, svec;
  logic [15:0] lfsr_q = 16'h6D84;
  logic rd, empty, eof, done, disc, sten, txen, txer;
  logic rxw, rxeof, rxerr, rxferr, hrdy_n, hoe_n;
  logic [7:0] exp_tx[$];
  logic [15:0] exp_st[$], exp_mk[$], exp_h[$];
  logic [1:0] exp_rx[$];
  int num_errors = 0, check_count = 0, cyc = 0, rate = 1, rcnt = 0;
  int n_stat = 0, n_done = 0, n_disc = 0, n_men = 0, pcnt = 0;
  // ==========================================
  // design and client fifo model
  tsc_mac #(.MDC_HALF(2)) dut (.CORE_CLK_IN(clk), .RESET_IN(rst),
    .CLK_EN_IN(cen), .TX_FIFO_DATA_IN(fdata), .TX_FIFO_EMPTY_IN(empty),
    .TX_FIFO_AVAIL_IN(avail), .TX_FIFO_EOF_IN(eof), .TX_MAC_READ_OUT(rd),
    .TX_DONE_OUT(done), .TX_DISCARD_OUT(disc), .TX_STAT_EN_OUT(sten),
    .TX_STAT_VEC_OUT(svec), .TXD_OUT(txd), .TX_EN_OUT(txen),
    .TX_ER_OUT(txer), .RXD_IN(rxd), .RX_EN_IN(rx_en), .RX_ER_IN(rx_er),
    .COL_IN(1'b0), .CRS_IN(crs), .RX_DATA_OUT(rxo), .RX_WRITE_OUT(rxw),
    .RX_EOF_OUT(rxeof), .RX_ERROR_OUT(rxerr), .RX_FIFO_ERROR_OUT(rxferr),
    .RX_FIFO_FULL_IN(full), .HADDR_IN(haddr), .HDATA_IN(hdata),
    .HCS_N_IN(hcs_n), .HWRITE_N_IN(hwr_n), .HREAD_N_IN(hrd_n),
    .HDATA_OUT(hdo), .HREADY_N_OUT(hrdy_n), .HDATAOUT_EN_N_OUT(hoe_n),
    .MDC_OUT(mdc), .MDO_OUT(mdo), .MDIO_EN_OUT(men), .MDI_IN(mdi));
  tsc_client_model cm (.clk_in(clk), .en_in(cen), .read_in(rd),
    .data_out(fdata), .empty_out(empty), .eof_out(eof));
  // ==========================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_word(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    chk_word(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic host(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
    int k = 0;
    haddr = a;
    hdata = d;
    hcs_n = 0;
    hwr_n = !w;
    hrd_n = w;
    do begin @(posedge clk); k++; end while (hrdy_n !== 1'b0 && k < 20);
    chk_bit("host ready", 1'b0, hrdy_n);
    #1 {hcs_n, hwr_n, hrd_n} = 3'h7;
    @(posedge clk);
    #1;
  endtask
  // one management frame: count enabled bits and compare them
  task automatic mdio_run(input logic [15:0] c, input int n,
                          input logic [63:0] e);
    mcap = '0;
    n_men = 0;
    host(1, 4'h2, c);
    repeat (300) @(posedge clk);
    #1 chk_word("mdio en bits", 16'(n), 16'(n_men));
    for (int i = 0; i < 64; i += 16)
      chk_word("mdo frame", e[i +: 16], mcap[i +: 16]);
  endtask
  task automatic load(input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      lfsr_q = lfsr(lfsr_q);
      cm.push(lfsr_q[7:0], last && i == n - 1);
      if (tx_chk) exp_tx.push_back(lfsr_q[7:0]);
    end
  endtask
  task automatic wait_stat(input int t, input logic [15:0] v, m);
    int k = 0;
    exp_st.push_back(v);
    exp_mk.push_back(m);
    avail = 1;
    while (n_stat < t && k < 5000) begin @(posedge clk); k++; end
    #1 avail = 0;
    chk_word("stat count", 16'(t), 16'(n_stat));
  endtask
  task automatic rx_frame(input logic err, input logic ovf);
    exp_rx.push_back({err, ovf});
    rx_chk = !ovf;
    for (int i = 0; i < 64; i++) begin
      lfsr_q = lfsr(lfsr_q);
      rxd = lfsr_q[7:0];
      if (!ovf) exp_rxd.push_back({i == 63, lfsr_q[7:0]});
      rx_en = 1;
      rx_er = err && i == 30;
      full = ovf && i >= 20;
      @(posedge clk);
      #1;
    end
    {rx_en, rx_er} = 2'h0;
    rxd = ~rxd;
    repeat (4) @(posedge clk);
    #1 full = 0;
    repeat (20) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // clock, rate enable and cycle ceiling
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    #1 rcnt = (rcnt + 1) % rate;
    cen = rcnt == 0;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; results(); end
  end
  // phy side of the management port: driven bits taken on the rise
  always @(posedge mdc) if (men) begin
    mcap = {mcap[62:0], mdo};
    n_men++;
  end
  // phy answers a read one bit per fall once the mac lets go
  always @(negedge mdc) begin
    #1 pcnt = men ? 0 : pcnt + 1;
    mdi = (pcnt >= 3 && pcnt <= 18) ? phy_dat[18 - pcnt] : 1'b1;
  end
  // compare outputs against the oldest noted expectation
  always @(posedge clk) if (!rst) begin
    if (cen && txen && !txer && tx_chk)
      chk_word("txd", {8'h00, exp_tx.pop_front()}, {8'h00, txd});
    if (cen && sten) begin
      n_stat++;
      chk_word("stat vec", exp_st.pop_front(), svec & exp_mk.pop_front());
    end
    if (cen && done) n_done++;
    if (cen && disc) n_disc++;
    if (rxw && !full && rxeof)
      chk_word("rx flags", {14'h0, exp_rx.pop_front()},
               {14'h0, rxerr, rxferr});
    if (rxw && !full && rx_chk)
      chk_word("rx byte", {7'h00, exp_rxd.pop_front()},
               {7'h00, rxeof, rxo});
    if (!hoe_n) begin
      chk_bit("read ready", 1'b0, hrdy_n);
      chk_word("hdata", exp_h.pop_front(), hdo);
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    exp_h.push_back(16'h000C);
    host(0, 4'h0, 16'h0000);
    host(1, 4'h0, 16'h0104);
    exp_h.push_back(16'h0104);
    host(0, 4'h0, 16'h0000);
    exp_h.push_back(16'h0000);
    host(0, 4'hA, 16'h0000);
    exp_h.push_back(16'h0003);
    host(0, 4'h1, 16'h0000);
    $display("test host done");
    host(1, 4'h3, 16'hB3C5);
    mdio_run(16'h250A, 64, {32'hFFFF_FFFF, 4'h5, 5'h05, 5'h0A, 2'h2,
                            16'hB3C5});
    mdio_run(16'h050A, 46, {18'h0, 32'hFFFF_FFFF, 4'h6, 5'h05, 5'h0A});
    exp_h.push_back(16'h9D26);
    host(0, 4'h3, 16'h0000);
    exp_h.push_back(16'h450A);
    host(0, 4'h2, 16'h0000);
    $display("test management done");
    load(20, 1);
    repeat (40) @(posedge clk);
    #1 chk_word("deferred", 16'd20, 16'(cm.fifo_q.size()));
    crs = 0;
    repeat (40) @(posedge clk);
    #1 chk_bit("read held", 1'b0, rd);
    chk_word("preread", 16'd12, 16'(cm.fifo_q.size()));
    wait_stat(1, 16'h0014, 16'hFFFF);
    repeat (30) @(posedge clk);
    #1 chk_bit("read released", 1'b0, rd);
    $display("test preread done");
    rate = 10;
    load(64, 1);
    wait_stat(2, 16'h0040, 16'hFFFF);
    rate = 1;
    $display("test slow rate done");
    tx_chk = 0;
    load(10, 0);
    wait_stat(3, 16'h8000, 16'h8000);
    tx_chk = 1;
    chk_word("done count", 16'd2, 16'(n_done));
    chk_word("discard count", 16'd1, 16'(n_disc));
    chk_word("tx left", 16'd0, 16'(exp_tx.size()));
    $display("test abort done");
    rx_frame(1, 0);
    rx_frame(0, 1);
    chk_word("rx left", 16'd0, 16'(exp_rx.size() + exp_rxd.size()));
    $display("test receive done");
    results();
  end
endmodule
